// ===== hdl/hcs_status_vector.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module hcs_status_vector (
  // clock and reset
  input  logic                             mclk,
  input  logic                             arst_n,
  // wishbone slave
  input  logic                             wb_cyc_i,
  input  logic                             wb_stb_i,
  input  logic                             wb_we_i,
  input  logic [3:0]                       wb_sel_i,
  input  logic [hcs_pkg::ADR_W-1:0]        wb_adr_i,
  input  logic [hcs_pkg::DAT_W-1:0]        wb_dat_i,
  output logic [hcs_pkg::DAT_W-1:0]        wb_dat_o,
  output logic                             wb_ack_o,
  // hdlc engine events and dsp buffer accesses
  input  hcs_pkg::hcs_event_t              ev,
  input  hcs_pkg::hcs_dsp_t                dsp,
  // configuration towards the engine, and the service map
  output logic                             processor_access_select,
  output logic [hcs_pkg::NCH-1:0]          crc_enable,
  output logic [hcs_pkg::NCH-1:0]          service_map,
  // interrupt
  output logic                             irq
);

  typedef struct packed {
    logic [hcs_pkg::NCH-1:0] no;
    logic [hcs_pkg::NCH-1:0] crc;
    logic [hcs_pkg::NCH-1:0] stop;
    logic [hcs_pkg::NCH-1:0] abort;
    logic [hcs_pkg::NCH-1:0] full;
    logic [hcs_pkg::NCH-1:0] empty;
    logic [hcs_pkg::NCH-1:0] crc_en;
    logic                    acc;
  } hcs_sv_state_t;

  hcs_sv_state_t                 s_q;
  hcs_sv_state_t                 s_d;
  hcs_pkg::hcs_wb_req_t          req;
  logic [hcs_pkg::DAT_W-1:0]     rdata;
  logic                          wr_commit;
  logic [hcs_pkg::IDX_W-1:0]     idx;
  logic [hcs_pkg::NCH-1:0]       no_n;
  logic [hcs_pkg::NCH-1:0]       crc_n;
  logic [hcs_pkg::NCH-1:0]       stop_n;
  logic [hcs_pkg::NCH-1:0]       abort_n;
  logic [hcs_pkg::NCH-1:0]       full_n;
  logic [hcs_pkg::NCH-1:0]       empty_n;
  logic [hcs_pkg::NCH-1:0]       rx_lost;
  logic [hcs_pkg::NCH-1:0]       tx_repeat;
  logic [hcs_pkg::NCH-1:0]       svc_rise;
  logic [hcs_pkg::NCH-1:0]       ab_rise;
  logic [hcs_pkg::IRQ_W-1:0]     irq_set;
  logic [hcs_pkg::IRQ_W-1:0]     irq_status;
  logic [hcs_pkg::IRQ_W-1:0]     irq_mask;
  logic                          irq_st_we;
  logic                          irq_mask_we;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic chan_hit(input logic vld, input logic [hcs_pkg::CHW-1:0] c,
                                    input logic [hcs_pkg::CHW-1:0] n);
    chan_hit = vld && (c == n);
  endfunction

  // status word of one channel; service flag follows full or empty
  function automatic logic [15:0] sv_word(input hcs_sv_state_t s, input logic [hcs_pkg::CHW-1:0] c);
    logic [15:0] w;
    w                    = 16'h0000;
    w[hcs_pkg::SV_NO]    = s.no[c];
    w[hcs_pkg::SV_CRC]   = s.crc[c];
    w[hcs_pkg::SV_STOP]  = s.stop[c];
    w[hcs_pkg::SV_ABORT] = s.abort[c];
    w[hcs_pkg::SV_FULL]  = s.full[c];
    w[hcs_pkg::SV_EMPTY] = s.empty[c];
    w[hcs_pkg::SV_FLAG]  = s.full[c] | s.empty[c];
    sv_word              = w;
  endfunction

  function automatic logic is_sv(input logic [hcs_pkg::IDX_W-1:0] i);
    is_sv = (i >= hcs_pkg::IDX_SV_BASE) && (i <= hcs_pkg::IDX_SV_LAST);
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we  = wb_we_i;
  assign req.sel = wb_sel_i;
  assign req.adr = wb_adr_i;
  assign req.dat = wb_dat_i;
  assign idx     = wb_adr_i[hcs_pkg::ADR_W-1:2];

  hcs_wb_slave u_slave (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .req       (req),
    .rdata     (rdata),
    .ack       (wb_ack_o),
    .dat       (wb_dat_o),
    .wr_commit (wr_commit)
  );

  // ----------------------------------------------------------------
  // read mux; unmapped reads return zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    if (is_sv(idx)) begin
      // locked words answer but show nothing
      if (s_q.acc) begin
        rdata = {16'h0000, sv_word(s_q, idx[hcs_pkg::CHW-1:0])};
      end
    end else if (idx == hcs_pkg::IDX_CTRL) begin
      rdata[hcs_pkg::CTRL_ACC] = s_q.acc;
    end else if (idx == hcs_pkg::IDX_CRC_EN) begin
      rdata = s_q.crc_en;
    end else if (idx == hcs_pkg::IDX_IRQ_ST) begin
      rdata[hcs_pkg::IRQ_W-1:0] = irq_status;
    end else if (idx == hcs_pkg::IDX_IRQ_MASK) begin
      rdata[hcs_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // per-channel flag updates; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < hcs_pkg::NCH; g++) begin : g_ch
      logic hit_ev;
      logic hit_rd;
      logic hit_wr;
      assign hit_ev = chan_hit(ev.valid, ev.chan, hcs_pkg::CHW'(g));
      assign hit_rd = chan_hit(dsp.rx_read, dsp.chan, hcs_pkg::CHW'(g));
      assign hit_wr = chan_hit(dsp.tx_write, dsp.chan, hcs_pkg::CHW'(g));
      // message flags describe the waiting octet and go with it
      assign no_n[g]    = (hit_ev && ev.not_octet) || (s_q.no[g] && !hit_rd);
      assign crc_n[g]   = (hit_ev && ev.crc_err && s_q.crc_en[g])
                          || (s_q.crc[g] && !hit_rd);
      assign stop_n[g]  = (hit_ev && (ev.end_flag || ev.abort))
                          || (s_q.stop[g] && !hit_rd);
      assign abort_n[g] = (hit_ev && ev.abort) || (s_q.abort[g] && !hit_rd);
      assign full_n[g]  = (hit_ev && ev.rx_octet) || (s_q.full[g] && !hit_rd);
      assign empty_n[g] = (hit_ev && ev.tx_done) || (s_q.empty[g] && !hit_wr);
      // unread octet overwritten, or a slot fetched again unchanged
      assign rx_lost[g]   = hit_ev && ev.rx_octet && s_q.full[g] && !hit_rd;
      assign tx_repeat[g] = hit_ev && ev.tx_done && s_q.empty[g] && !hit_wr;
      assign svc_rise[g]  = !(s_q.full[g] || s_q.empty[g]) && (full_n[g] || empty_n[g]);
      assign ab_rise[g]   = abort_n[g] && !s_q.abort[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.no    = no_n;
    s_d.crc   = crc_n;
    s_d.stop  = stop_n;
    s_d.abort = abort_n;
    s_d.full  = full_n;
    s_d.empty = empty_n;
    // status words take no writes at all
    if (wr_commit) begin
      if (idx == hcs_pkg::IDX_CTRL) begin
        if (wb_sel_i[0]) begin
          s_d.acc = wb_dat_i[hcs_pkg::CTRL_ACC];
        end
      end else if (idx == hcs_pkg::IDX_CRC_EN) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            s_d.crc_en[b*8 +: 8] = wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.no     <= hcs_pkg::FLAGS_RST;
      s_q.crc    <= hcs_pkg::FLAGS_RST;
      s_q.stop   <= hcs_pkg::FLAGS_RST;
      s_q.abort  <= hcs_pkg::FLAGS_RST;
      s_q.full   <= hcs_pkg::FLAGS_RST;
      s_q.empty  <= hcs_pkg::FLAGS_RST;
      s_q.crc_en <= hcs_pkg::CRC_EN_RST;
      s_q.acc    <= hcs_pkg::CTRL_ACC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign processor_access_select = s_q.acc;
  assign crc_enable              = s_q.crc_en;
  assign service_map             = s_q.full | s_q.empty;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_set[hcs_pkg::IRQ_SERVICE]   = |svc_rise;
  assign irq_set[hcs_pkg::IRQ_ABORT]     = |ab_rise;
  assign irq_set[hcs_pkg::IRQ_RX_LOST]   = |rx_lost;
  assign irq_set[hcs_pkg::IRQ_TX_REPEAT] = |tx_repeat;
  assign irq_st_we   = wr_commit && wb_sel_i[0] && (idx == hcs_pkg::IDX_IRQ_ST);
  assign irq_mask_we = wr_commit && wb_sel_i[0] && (idx == hcs_pkg::IDX_IRQ_MASK);

  hcs_irq u_irq (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .ev_set  (irq_set),
    .st_we   (irq_st_we),
    .mask_we (irq_mask_we),
    .wdat    (wb_dat_i[hcs_pkg::IRQ_W-1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_sv_req;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && is_sv(idx);
  endsequence

  sequence s_ev_rx;
    ev.valid && ev.rx_octet && !(dsp.rx_read && dsp.chan == ev.chan);
  endsequence

  property p_ro_upper;
    s_sv_req |=> wb_ack_o && (wb_dat_o[31:hcs_pkg::SV_BITS] == '0);
  endproperty
  a_ro_upper: assert property (p_ro_upper) else $error("status word upper bits not zero");

  property p_locked;
    s_sv_req ##0 !s_q.acc |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_locked: assert property (p_locked) else $error("locked status word showed data");

  property p_open_read;
    s_sv_req ##0 s_q.acc ##1 wb_ack_o |-> wb_dat_o[15:0] == sv_word($past(s_q), $past(idx[4:0]));
  endproperty
  a_open_read: assert property (p_open_read) else $error("status word read mismatch");

  property p_not_octet;
    ev.valid && ev.not_octet |=> s_q.no[$past(ev.chan)];
  endproperty
  a_not_octet: assert property (p_not_octet) else $error("not-octet flag not set");

  property p_crc;
    ev.valid && ev.crc_err |=> s_q.crc[$past(ev.chan)] == $past(s_q.crc_en[ev.chan]) || $past(s_q.crc[ev.chan]);
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag not gated by crc enable");

  property p_abort_stop;
    ev.valid && ev.abort |=> s_q.abort[$past(ev.chan)] && s_q.stop[$past(ev.chan)];
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort without stop");

  property p_full_svc;
    s_ev_rx |=> s_q.full[$past(ev.chan)] && service_map[$past(ev.chan)];
  endproperty
  a_full_svc: assert property (p_full_svc) else $error("full or service flag missing");

  property p_empty_clr;
    dsp.tx_write && !(ev.valid && ev.tx_done && ev.chan == dsp.chan) |=> !s_q.empty[$past(dsp.chan)];
  endproperty
  a_empty_clr: assert property (p_empty_clr) else $error("empty flag not cleared by load");

  property p_svc_irq;
    ev.valid && ev.tx_done && !s_q.full[ev.chan] && !s_q.empty[ev.chan] && irq_mask[hcs_pkg::IRQ_SERVICE]
      |-> ##[1:2] irq;
  endproperty
  a_svc_irq: assert property (p_svc_irq) else $error("service event raised no interrupt");

  property p_sv_nowrite;
    wr_commit && is_sv(idx) |=> s_q.acc == $past(s_q.acc) && s_q.crc_en == $past(s_q.crc_en);
  endproperty
  a_sv_nowrite: assert property (p_sv_nowrite) else $error("status word write changed state");

  // receive read with no event racing it on the same channel
  sequence s_rd_ch;
    dsp.rx_read && !(ev.valid && ev.chan == dsp.chan);
  endsequence

  property p_rx_clear;
    s_rd_ch |=> !s_q.full[$past(dsp.chan)] && !s_q.stop[$past(dsp.chan)] && !s_q.abort[$past(dsp.chan)];
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive read left message flags set");

  property p_msg_clear;
    s_rd_ch |=> !s_q.no[$past(dsp.chan)] && !s_q.crc[$past(dsp.chan)];
  endproperty
  a_msg_clear: assert property (p_msg_clear) else $error("receive read left octet or crc flag set");

  property p_svc_drop;
    s_rd_ch ##0 !s_q.empty[dsp.chan] |=> !service_map[$past(dsp.chan)];
  endproperty
  a_svc_drop: assert property (p_svc_drop) else $error("service flag stayed after last reason cleared");

  property p_stop_end;
    ev.valid && ev.end_flag |=> s_q.stop[$past(ev.chan)];
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("end of message left stop clear");

  property p_empty_set;
    ev.valid && ev.tx_done |=> s_q.empty[$past(ev.chan)] && service_map[$past(ev.chan)];
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("slot done but empty or service clear");

  property p_crc_off;
    ev.valid && !s_q.crc_en[ev.chan] && !s_q.crc[ev.chan] |=> !s_q.crc[$past(ev.chan)];
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc flag set without crc check");

  property p_acc_write;
    wr_commit && wb_sel_i[0] && idx == hcs_pkg::IDX_CTRL
      |=> processor_access_select == $past(wb_dat_i[hcs_pkg::CTRL_ACC]);
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("access select did not take the write");

  // every address answers, locked status words included
  property p_req_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_req_ack: assert property (p_req_ack) else $error("request not answered in one cycle");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");

endmodule

// ===== hdl/hcs_pkg.sv
package hcs_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NCH   = 32;
  localparam int unsigned CHW   = 5;
  localparam int unsigned ADR_W = 18;
  localparam int unsigned IDX_W = 16;
  localparam int unsigned DAT_W = 32;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SV_BASE  = 16'h40A0;
  localparam logic [15:0] IDX_SV_LAST  = 16'h40BF;
  localparam logic [15:0] IDX_CTRL     = 16'h40C0;
  localparam logic [15:0] IDX_CRC_EN   = 16'h40C1;
  localparam logic [15:0] IDX_IRQ_ST   = 16'h40C2;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h40C3;

  // ----------------------------------------------------------------
  // status vector fields
  // ----------------------------------------------------------------
  localparam int unsigned SV_NO    = 0;
  localparam int unsigned SV_CRC   = 1;
  localparam int unsigned SV_STOP  = 2;
  localparam int unsigned SV_ABORT = 3;
  localparam int unsigned SV_FULL  = 4;
  localparam int unsigned SV_EMPTY = 5;
  localparam int unsigned SV_FLAG  = 6;
  localparam int unsigned SV_BITS  = 7;

  // ----------------------------------------------------------------
  // control, interrupt fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ACC      = 0;
  localparam int unsigned IRQ_SERVICE   = 0;
  localparam int unsigned IRQ_ABORT     = 1;
  localparam int unsigned IRQ_RX_LOST   = 2;
  localparam int unsigned IRQ_TX_REPEAT = 3;
  localparam int unsigned IRQ_W         = 4;

  localparam logic        CTRL_ACC_RST = 1'b0;
  localparam logic [31:0] CRC_EN_RST   = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST    = 32'h0000_0000;
  localparam logic [3:0]  IRQ_ST_RST   = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } hcs_wb_req_t;

  typedef struct packed {
    logic           valid;
    logic [CHW-1:0] chan;
    logic           rx_octet;
    logic           end_flag;
    logic           abort;
    logic           crc_err;
    logic           not_octet;
    logic           tx_done;
  } hcs_event_t;

  typedef struct packed {
    logic           rx_read;
    logic           tx_write;
    logic [CHW-1:0] chan;
  } hcs_dsp_t;

endpackage

// ===== hdl/hcs_wb_slave.sv
`timescale 1ns/1ps
module hcs_wb_slave (
  // clock and reset
  input  logic                           mclk,
  input  logic                           arst_n,
  // bus request and read data from the register file
  input  hcs_pkg::hcs_wb_req_t           req,
  input  logic [hcs_pkg::DAT_W-1:0]      rdata,
  // answer
  output logic                           ack,
  output logic [hcs_pkg::DAT_W-1:0]      dat,
  output logic                           wr_commit
);

  typedef struct packed {
    logic                      ack;
    logic [hcs_pkg::DAT_W-1:0] dat;
  } hcs_slv_state_t;

  hcs_slv_state_t s_q;
  hcs_slv_state_t s_d;

  // ----------------------------------------------------------------
  // one wait state: data is captured with the request, ack follows
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.ack = req.cyc && req.stb && !s_q.ack;
    if (req.cyc && req.stb && !s_q.ack) begin
      s_d.dat = rdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // write lands on the edge at which the master samples ack
  assign ack       = s_q.ack;
  assign dat       = s_q.dat;
  assign wr_commit = s_q.ack && req.cyc && req.stb && req.we;

endmodule

// ===== hdl/hcs_irq.sv
`timescale 1ns/1ps
module hcs_irq (
  // clock and reset
  input  logic                        mclk,
  input  logic                        arst_n,
  // events
  input  logic [hcs_pkg::IRQ_W-1:0]   ev_set,
  // software access
  input  logic                        st_we,
  input  logic                        mask_we,
  input  logic [hcs_pkg::IRQ_W-1:0]   wdat,
  // state
  output logic [hcs_pkg::IRQ_W-1:0]   status,
  output logic [hcs_pkg::IRQ_W-1:0]   mask,
  output logic                        irq
);

  typedef struct packed {
    logic [hcs_pkg::IRQ_W-1:0] st;
    logic [hcs_pkg::IRQ_W-1:0] mask;
  } hcs_irq_state_t;

  hcs_irq_state_t s_q;
  hcs_irq_state_t s_d;

  // ----------------------------------------------------------------
  // sticky status, write one to clear; a new event beats the clear
  // ----------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    s_d.st = (s_q.st & ~(st_we ? wdat : '0)) | ev_set;
    if (mask_we) begin
      s_d.mask = wdat;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.st   <= hcs_pkg::IRQ_ST_RST;
      s_q.mask <= hcs_pkg::IRQ_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.st;
  assign mask   = s_q.mask;
  assign irq    = |(s_q.st & s_q.mask);

endmodule

// ===== bench/hcs_dsp_model.sv
`timescale 1ns/1ps
module hcs_dsp_model (
  // clock and reset
  input  logic                        mclk,
  input  logic                        arst_n,
  // flags from the device
  input  logic [hcs_pkg::NCH-1:0]     service_map,
  // buffer strobes
  output hcs_pkg::hcs_dsp_t           dsp
);
  initial dsp = '0;

  // ----------------------------------------------------------------
  // one buffer access, entered right after a rising edge
  // ----------------------------------------------------------------
  // dly lets the bench play a slow core
  task automatic access(input logic rd, input logic [hcs_pkg::CHW-1:0] ch, input int dly);
    logic ok;
    repeat (dly) @(posedge mclk);
    @(negedge mclk);
    ok = (arst_n === 1'b1) && (service_map[ch] === 1'b1);
    @(posedge mclk);
    if (!ok) return;
    dsp.chan     <= ch;
    dsp.rx_read  <= rd;
    dsp.tx_write <= !rd;
    @(posedge mclk);
    dsp <= '0;
    @(posedge mclk);
  endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                 mclk;
  logic                 arst_n;
  logic                 wb_cyc;
  logic                 wb_stb;
  logic                 wb_we;
  logic [3:0]           wb_sel;
  logic [17:0]          wb_adr;
  logic [31:0]          wb_dat;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  hcs_pkg::hcs_event_t  ev;
  hcs_pkg::hcs_dsp_t    dsp;
  logic                 acc_sel;
  logic [31:0]          crc_en;
  logic [31:0]          svc_map;
  logic                 irq;
  logic [6:0]           sv_exp [32];
  logic [31:0]          crc_exp;
  logic [31:0]          r;
  int                   error_cnt;
  int                   compares;
  int                   seed;

  always #50 mclk = ~mclk;

  hcs_status_vector u_hcs_status_vector (
    .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ev(ev), .dsp(dsp), .processor_access_select(acc_sel), .crc_enable(crc_en),
    .service_map(svc_map), .irq(irq)
  );

  hcs_dsp_model u_hcs_dsp_model (.mclk(mclk), .arst_n(arst_n), .service_map(svc_map), .dsp(dsp));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // entered and left right after a rising edge; leaves one idle cycle
  task automatic wb_xfer(input logic we, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_sel <= 4'hF;
    wb_adr <= {idx, 2'b00};
    wb_dat <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
    if (n >= 50) check("wb_ack", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] j;
    wb_xfer(1'b1, idx, d, j);
  endtask

  task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, idx, 32'h0, d);
    check(name, exp, d);
  endtask

  function automatic hcs_pkg::hcs_event_t mk(input logic [4:0] ch, input logic [5:0] b);
    return {1'b1, ch, b};
  endfunction

  function automatic logic [6:0] ev_apply(input logic [6:0] f, input hcs_pkg::hcs_event_t e, input logic crc_on);
    logic [6:0] n;
    n = f;
    if (e.rx_octet) n[4] = 1'b1;
    if (e.end_flag || e.abort) n[2] = 1'b1;
    if (e.abort) n[3] = 1'b1;
    if (e.crc_err && crc_on) n[1] = 1'b1;
    if (e.not_octet) n[0] = 1'b1;
    if (e.tx_done) n[5] = 1'b1;
    n[6] = n[4] | n[5];
    if (!e.valid) n = f;
    return n;
  endfunction

  // a skipped channel is left alone by the core
  function automatic logic [6:0] dsp_apply(input logic [6:0] f, input logic rd);
    logic [6:0] n;
    n = rd ? (f & 7'h20) : (f & 7'h1F);
    n[6] = n[4] | n[5];
    return f[6] ? n : f;
  endfunction

  function automatic logic [31:0] map_exp();
    logic [31:0] m;
    for (int i = 0; i < 32; i++) m[i] = sv_exp[i][6];
    return m;
  endfunction

  task automatic step(input hcs_pkg::hcs_event_t e, input logic act, input logic rd, input logic [4:0] ch2,
                      input int dly);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
    sv_exp[e.chan] = ev_apply(sv_exp[e.chan], e, crc_exp[e.chan]);
    if (act) begin
      u_hcs_dsp_model.access(rd, ch2, dly);
      sv_exp[ch2] = dsp_apply(sv_exp[ch2], rd);
    end
    @(negedge mclk);
    check("service_map", map_exp(), svc_map);
    @(posedge mclk);
    rd_chk("status_word", hcs_pkg::IDX_SV_BASE + 16'(e.chan), {25'h0, sv_exp[e.chan]});
    rd_chk("status_word", hcs_pkg::IDX_SV_BASE + 16'(ch2), {25'h0, sv_exp[ch2]});
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    mclk = 1'b0; arst_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
    wb_sel = 4'h0; wb_adr = 18'h0; wb_dat = 32'h0; ev = '0; crc_exp = 32'h0;
    seed = 33; error_cnt = 0; compares = 0;
    for (int i = 0; i < 32; i++) sv_exp[i] = 7'h00;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd_chk("ctrl", hcs_pkg::IDX_CTRL, {31'h0, hcs_pkg::CTRL_ACC_RST});
    rd_chk("crc_enable", hcs_pkg::IDX_CRC_EN, hcs_pkg::CRC_EN_RST);
    rd_chk("irq_status", hcs_pkg::IDX_IRQ_ST, {28'h0, hcs_pkg::IRQ_ST_RST});
    rd_chk("irq_mask", hcs_pkg::IDX_IRQ_MASK, {28'h0, hcs_pkg::IRQ_MASK_RST});
    $display("test reset done");
    // flags move while gated, reads stay blank
    ev <= mk(5'd3, 6'b100000);
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
    sv_exp[3] = ev_apply(sv_exp[3], mk(5'd3, 6'b100000), 1'b0);
    rd_chk("gated_word", hcs_pkg::IDX_SV_BASE + 16'h3, 32'h0);
    wr(hcs_pkg::IDX_CTRL, 32'h1);
    check("access_select", 32'h1, {31'h0, acc_sel});
    rd_chk("status_word", hcs_pkg::IDX_SV_BASE + 16'h3, 32'h50);
    wr(hcs_pkg::IDX_SV_BASE + 16'h3, 32'hFFFF_FFFF);
    rd_chk("ro_word", hcs_pkg::IDX_SV_BASE + 16'h3, 32'h50);
    rd_chk("unmapped", 16'h0100, 32'h0);
    $display("test access done");
    crc_exp = $random(seed);
    crc_exp[7] = 1'b0;
    crc_exp[8] = 1'b1;
    wr(hcs_pkg::IDX_CRC_EN, crc_exp);
    check("crc_enable", crc_exp, crc_en);
    step(mk(5'd0, 6'b001000), 1'b0, 1'b0, 5'd0, 0);
    step(mk(5'd7, 6'b000100), 1'b0, 1'b0, 5'd7, 0);
    step(mk(5'd8, 6'b000100), 1'b0, 1'b0, 5'd8, 0);
    step(mk(5'd31, 6'b010011), 1'b1, 1'b0, 5'd31, 3);
    step(mk(5'd9, 6'b100000), 1'b1, 1'b1, 5'd3, 0);
    step(mk(5'd0, 6'b000000), 1'b1, 1'b1, 5'd0, 1);
    $display("test corners done");
    wr(hcs_pkg::IDX_IRQ_ST, 32'hF);
    wr(hcs_pkg::IDX_IRQ_MASK, 32'h1);
    step(mk(5'd12, 6'b100000), 1'b0, 1'b0, 5'd12, 0);
    check("irq_on", 32'h1, {31'h0, irq});
    wr(hcs_pkg::IDX_IRQ_ST, 32'hF);
    check("irq_cleared", 32'h0, {31'h0, irq});
    wr(hcs_pkg::IDX_IRQ_MASK, 32'h0);
    step(mk(5'd13, 6'b000001), 1'b0, 1'b0, 5'd13, 0);
    check("irq_masked", 32'h0, {31'h0, irq});
    rd_chk("irq_status", hcs_pkg::IDX_IRQ_ST, 32'h1);
    $display("test interrupt done");
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      step({r[0], r[5:1], r[11:6]}, r[12], r[13], r[18:14], int'(r[20:19]));
    end
    $display("test random done");
    complete_run();
  end
endmodule
